// >>> verilog/grac_control.sv
// grac_control: command memory, status memory and motion sequencing.
// assumes a byte register link: one-cycle write and read strobes,
// motor current sampled from the drive, all synchronous to clk.
// only faults 0x07 and 0x0F are raised; go-to before activation is ignored.
//
// How it works
// - byte indices in both memories count from zero.
// - writes land in the command memory, reads come from the status memory.
// - bytes 3, 4, 5 give target position, speed and force.
// - bit 0 of byte 0 activates; host sets it before anything else.
// - clearing activate resets the gripper and clears faults.
// - activate going to one starts the activation motion.
// - after power-up activate reads set; a clear then set is needed.
// - activate must stay set; nothing happens while it is clear.
// - go-to bit moves fingers to target with speed and force; clear stops.
// - no motion without go-to, except activation and auto release.
// - auto release drives fingers slowly to their mechanical limit.
// - when release finishes, raise a fault and refuse further motion.
// - auto release overrides all command bits except activate.
// - after release, activate must be cleared then set to resume.
// - release direction bit 5: zero closes, one opens.
// - release direction is captured when the release starts.
// - both fingers always move together.
// - object pick is reported in status after a go-to.
// - go-to bit is echoed in the status byte only once activation is done and no release has started.
// - finished release reports fault code 0x0F.
// - action requested while not activated reports fault 0x07.
`timescale 1ns/1ps
module grac_control
    import grac_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter logic [7:0] ACT_SPEED = GRAC_SPEED_ACT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic [7:0] motor_current,
    output logic [7:0] finger_position,
    output logic motion_active
);

    grac_action_t action_request_q;
    logic [7:0] target_position_q;
    logic [7:0] speed_setting_q;
    logic [7:0] force_setting_q;
    logic [7:0] fault_code_q;
    logic [1:0] obj_q;
    logic [1:0] obj_d;
    logic act_prev_q;
    logic rel_dir_q;
    logic contact_q;
    grac_mode_t mode_q;
    grac_mode_t mode_d;
    grac_action_t wr_action;
    grac_status_t status_byte;
    logic act_rise;
    logic act_on;
    logic goto_on;
    logic release_on;
    logic drive_run;
    logic [7:0] drive_target;
    logic [7:0] drive_speed;
    logic [7:0] pos;
    logic at_target;
    logic closing;
    logic contact_hit;
    logic wr_action_sel;
    logic new_motion;
    logic act_clear_wr;
    logic act_missing_wr;
    logic rel_start;
    logic rel_done;

    initial begin
        if (ADDR_W < 4) begin
            $error("grac_control: address must reach 16 bytes");
        end
    end

    // address decode shared by write and read paths
    function automatic logic idx_is(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
        idx_is = (a == ADDR_W'(idx));
    endfunction : idx_is

    // incoming byte seen as an action request, reserved bits dropped
    assign wr_action = grac_action_t'(reg_wdata & GRAC_ACTION_WMASK);
    assign wr_action_sel = reg_wr && idx_is(reg_addr, GRAC_IDX_ACTION);

    // command bit views
    assign act_on = action_request_q.activate_request_bit;
    assign goto_on = action_request_q.goto_request_bit;
    assign release_on = action_request_q.auto_release_request_bit;
    assign act_rise = act_on && !act_prev_q;

    // command events shared by the fault and release logic
    assign act_clear_wr = wr_action_sel && !wr_action.activate_request_bit;
    assign act_missing_wr = act_clear_wr &&
        (wr_action.goto_request_bit || wr_action.auto_release_request_bit);
    assign rel_start = (mode_q != MODE_RELEASE) && (mode_d == MODE_RELEASE);
    assign rel_done = (mode_q == MODE_RELEASE) && (mode_d == MODE_LOCKED);

    // action byte, reset value mimics power loss with activate set
    always_ff @(posedge clk) begin
        if (reset) begin
            action_request_q <= grac_action_t'(GRAC_ACTION_RESET);
        end else if (ce && wr_action_sel) begin
            action_request_q <= wr_action;
        end
    end

    // motion parameter bytes
    always_ff @(posedge clk) begin
        if (reset) begin
            target_position_q <= GRAC_BYTE_ZERO;
            speed_setting_q <= GRAC_BYTE_ZERO;
            force_setting_q <= GRAC_BYTE_ZERO;
        end else if (ce && reg_wr) begin
            if (idx_is(reg_addr, GRAC_IDX_TARGET)) begin
                target_position_q <= reg_wdata;
            end
            if (idx_is(reg_addr, GRAC_IDX_SPEED)) begin
                speed_setting_q <= reg_wdata;
            end
            if (idx_is(reg_addr, GRAC_IDX_FORCE)) begin
                force_setting_q <= reg_wdata;
            end
        end
    end

    // previous activate level; reset holds it high so no edge appears
    // the host must clear then set activate after power-up
    always_ff @(posedge clk) begin
        if (reset) begin
            act_prev_q <= 1'b1;
        end else if (ce) begin
            act_prev_q <= act_on;
        end
    end

    // sequencing of activation, motion and release
    // activate clear beats everything, auto release beats go-to
    always_comb begin
        mode_d = mode_q;
        if (!act_on) begin
            mode_d = MODE_IDLE;
        end else begin
            unique case (mode_q)
                MODE_IDLE: begin
                    if (act_rise) begin
                        mode_d = MODE_ACTIVATE;
                    end
                end
                MODE_ACTIVATE: begin
                    if (release_on) begin
                        mode_d = MODE_RELEASE;
                    end else if (at_target) begin
                        mode_d = MODE_READY;
                    end
                end
                MODE_READY: begin
                    if (release_on) begin
                        mode_d = MODE_RELEASE;
                    end
                end
                MODE_RELEASE: begin
                    if (at_target) begin
                        mode_d = MODE_LOCKED;
                    end
                end
                MODE_LOCKED: begin
                    mode_d = MODE_LOCKED;
                end
            endcase
        end
    end

    // mode register
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_q <= MODE_IDLE;
        end else if (ce) begin
            mode_q <= mode_d;
        end
    end

    // release direction frozen on entry to the release
    always_ff @(posedge clk) begin
        if (reset) begin
            rel_dir_q <= 1'b0;
        end else if (ce && rel_start) begin
            rel_dir_q <= action_request_q.release_direction_bit;
        end
    end

    // drive target and speed per mode
    // a pending release freezes the go-to ramp before the mode moves
    always_comb begin
        drive_target = pos;
        drive_speed = speed_setting_q;
        drive_run = 1'b0;
        unique case (mode_q)
            MODE_IDLE: begin
                drive_run = 1'b0;
            end
            MODE_ACTIVATE: begin
                drive_target = GRAC_POS_OPEN;
                drive_speed = ACT_SPEED;
                drive_run = 1'b1;
            end
            MODE_READY: begin
                drive_target = target_position_q;
                drive_run = goto_on && !contact_q && !release_on;
            end
            MODE_RELEASE: begin
                drive_target = rel_dir_q ? GRAC_POS_OPEN : GRAC_POS_CLOSED;
                drive_speed = GRAC_SPEED_SLOW;
                drive_run = 1'b1;
            end
            MODE_LOCKED: begin
                drive_run = 1'b0;
            end
        endcase
    end

    // one ramp for both fingers
    grac_finger_drive #(
        .POS_W(8)
    ) u_drive (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .run(drive_run),
        .target(drive_target),
        .speed(drive_speed),
        .pos_q(pos),
        .at_target(at_target)
    );

    // contact: current beyond the force limit before the target
    // only a go-to in progress can report an object
    assign closing = drive_target > pos;
    assign contact_hit = drive_run && (mode_q == MODE_READY) && !at_target && (motor_current > force_setting_q);
    assign new_motion = wr_action_sel || (reg_wr && idx_is(reg_addr, GRAC_IDX_TARGET));

    // contact stop holds until the host issues a new command
    always_ff @(posedge clk) begin
        if (reset) begin
            contact_q <= 1'b0;
        end else if (ce) begin
            if (contact_hit) begin
                contact_q <= 1'b1;
            end else if (new_motion || mode_q != MODE_READY) begin
                contact_q <= 1'b0;
            end
        end
    end

    // object detection status
    always_comb begin
        obj_d = obj_q;
        if (mode_q != MODE_READY || !goto_on || new_motion) begin
            obj_d = GRAC_OBJ_MOVING;
        end else if (contact_hit) begin
            obj_d = closing ? GRAC_OBJ_CLOSING : GRAC_OBJ_OPENING;
        end else if (at_target && !contact_q) begin
            obj_d = GRAC_OBJ_AT_TARGET;
        end
    end

    // object status register
    always_ff @(posedge clk) begin
        if (reset) begin
            obj_q <= GRAC_OBJ_MOVING;
        end else if (ce) begin
            obj_q <= obj_d;
        end
    end

    // fault code: cleared by a write that drops activate,
    // a new fault in the same cycle wins
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_code_q <= GRAC_FLT_NONE;
        end else if (ce) begin
            if (act_clear_wr) begin
                fault_code_q <= GRAC_FLT_NONE;
            end
            if (rel_done) begin
                fault_code_q <= GRAC_FLT_REL_DONE;
            end
            if (act_missing_wr) begin
                fault_code_q <= GRAC_FLT_NO_ACT;
            end
        end
    end

    // status byte assembly
    always_comb begin
        status_byte = '0;
        status_byte.act_echo = act_on;
        status_byte.goto_echo_bit = act_on && goto_on && mode_q == MODE_READY;
        status_byte.obj = obj_q;
        unique case (mode_q)
            MODE_ACTIVATE: status_byte.sta = GRAC_STA_ACTIVATING;
            MODE_READY: status_byte.sta = GRAC_STA_DONE;
            MODE_IDLE, MODE_RELEASE, MODE_LOCKED: status_byte.sta = GRAC_STA_RESET;
        endcase
    end

    // read port returns the status memory, unmapped bytes read zero
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata_q <= GRAC_BYTE_ZERO;
        end else if (ce && reg_rd) begin
            if (idx_is(reg_addr, GRAC_IDX_ACTION)) begin
                reg_rdata_q <= status_byte;
            end else if (idx_is(reg_addr, GRAC_IDX_FAULT)) begin
                reg_rdata_q <= fault_code_q;
            end else if (idx_is(reg_addr, GRAC_IDX_TARGET)) begin
                reg_rdata_q <= target_position_q;
            end else if (idx_is(reg_addr, GRAC_IDX_SPEED)) begin
                reg_rdata_q <= pos;
            end else if (idx_is(reg_addr, GRAC_IDX_FORCE)) begin
                reg_rdata_q <= motor_current;
            end else begin
                reg_rdata_q <= GRAC_BYTE_ZERO;
            end
        end
    end

    // outward views
    assign finger_position = pos;
    assign motion_active = drive_run && !at_target;

endmodule : grac_control

// >>> verilog/grac_pkg.sv
// grac_pkg: constants and carriers for the gripper action request control.
// assumes one 10 MHz clock and a byte-wide register link.
package grac_pkg;

    // byte indices, command and status regions both start at zero
    localparam logic [3:0] GRAC_IDX_ACTION = 4'h0;
    localparam logic [3:0] GRAC_IDX_SPARE1 = 4'h1;
    localparam logic [3:0] GRAC_IDX_FAULT = 4'h2;
    localparam logic [3:0] GRAC_IDX_TARGET = 4'h3;
    localparam logic [3:0] GRAC_IDX_SPEED = 4'h4;
    localparam logic [3:0] GRAC_IDX_FORCE = 4'h5;

    // reset values and the action write mask
    localparam logic [7:0] GRAC_ACTION_RESET = 8'h01;
    localparam logic [7:0] GRAC_ACTION_WMASK = 8'h39;
    localparam logic [7:0] GRAC_BYTE_ZERO = 8'h00;

    // finger positions and drive speeds
    localparam logic [7:0] GRAC_POS_OPEN = 8'h00;
    localparam logic [7:0] GRAC_POS_CLOSED = 8'hFF;
    localparam logic [7:0] GRAC_SPEED_SLOW = 8'h00;
    localparam logic [7:0] GRAC_SPEED_ACT = 8'h80;

    // fault codes
    localparam logic [7:0] GRAC_FLT_NONE = 8'h00;
    localparam logic [7:0] GRAC_FLT_NO_ACT = 8'h07;
    localparam logic [7:0] GRAC_FLT_REL_DONE = 8'h0F;

    // gripper state field
    localparam logic [1:0] GRAC_STA_RESET = 2'h0;
    localparam logic [1:0] GRAC_STA_ACTIVATING = 2'h1;
    localparam logic [1:0] GRAC_STA_DONE = 2'h3;

    // object field
    localparam logic [1:0] GRAC_OBJ_MOVING = 2'h0;
    localparam logic [1:0] GRAC_OBJ_OPENING = 2'h1;
    localparam logic [1:0] GRAC_OBJ_CLOSING = 2'h2;
    localparam logic [1:0] GRAC_OBJ_AT_TARGET = 2'h3;

    // command byte 0 layout
    typedef struct packed {
        logic [1:0] spare_hi;
        logic release_direction_bit;
        logic auto_release_request_bit;
        logic goto_request_bit;
        logic [1:0] spare_lo;
        logic activate_request_bit;
    } grac_action_t;

    // status byte 0 layout
    typedef struct packed {
        logic [1:0] obj;
        logic [1:0] sta;
        logic goto_echo_bit;
        logic [1:0] spare;
        logic act_echo;
    } grac_status_t;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_ACTIVATE,
        MODE_READY,
        MODE_RELEASE,
        MODE_LOCKED
    } grac_mode_t;

endpackage : grac_pkg

// >>> verilog/grac_finger_drive.sv
// grac_finger_drive: one position ramp shared by both fingers.
// assumes the caller holds run only while motion is allowed.
`timescale 1ns/1ps
module grac_finger_drive
    import grac_pkg::*;
#(
    parameter int POS_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic run,
    input wire logic [POS_W-1:0] target,
    input wire logic [7:0] speed,
    output logic [POS_W-1:0] pos_q,
    output logic at_target
);

    logic [8:0] acc_sum;
    logic [7:0] acc_q;

    initial begin
        if (POS_W != 8) begin
            $error("grac_finger_drive: position must be 8 bits");
        end
    end

    // phase accumulator, faster speed steps more often
    assign acc_sum = {1'b0, acc_q} + {1'b0, speed} + 9'h001;
    assign at_target = (pos_q == target);

    // accumulator state
    always_ff @(posedge clk) begin
        if (reset) begin
            acc_q <= GRAC_BYTE_ZERO;
        end else if (ce) begin
            acc_q <= run ? acc_sum[7:0] : GRAC_BYTE_ZERO;
        end
    end

    // single position, fingers can never diverge
    always_ff @(posedge clk) begin
        if (reset) begin
            pos_q <= GRAC_POS_OPEN;
        end else if (ce && run && acc_sum[8] && !at_target) begin
            if (target > pos_q) begin
                pos_q <= pos_q + 8'h01;
            end else begin
                pos_q <= pos_q - 8'h01;
            end
        end
    end

endmodule : grac_finger_drive

// >>> testbench/grac_control_chk.sv
// grac_control_chk: port-level assertions on the register link and motion.
// assumes a bind onto grac_control, one clock, synchronous reset.
`timescale 1ns/1ps
module grac_control_chk
    import grac_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic [7:0] motor_current,
    input wire logic [7:0] finger_position,
    input wire logic motion_active
);
    logic go_q;
    logic quiet_q;
    logic zero_q;
    logic tgt_ok_q;
    logic [7:0] tgt_q;

    // idle until byte 0 sees activate cleared then set
    always_ff @(posedge clk) begin
        if (reset) begin
            go_q <= 1'b0;
            quiet_q <= 1'b1;
            zero_q <= 1'b0;
        end else if (ce && reg_wr && reg_addr == GRAC_IDX_ACTION) begin
            go_q <= reg_wdata[3];
            if (!reg_wdata[0]) begin
                quiet_q <= 1'b1;
                zero_q <= 1'b1;
            end else if (zero_q) begin
                quiet_q <= 1'b0;
                zero_q <= 1'b0;
            end
        end
    end

    // last target byte written
    always_ff @(posedge clk) begin
        if (reset) begin
            tgt_ok_q <= 1'b0;
        end else if (ce && reg_wr && reg_addr == GRAC_IDX_TARGET) begin
            tgt_ok_q <= 1'b1;
            tgt_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_rd(logic [3:0] idx);
        ce && reg_rd && reg_addr == idx;
    endsequence

    rd_spare_zero_a: assert property (ce && reg_rd && (reg_addr == 1 || reg_addr > 5) |=> reg_rdata_q == 8'h00)
        else $error("spare status byte not zero");
    rd_current_a: assert property (s_rd(GRAC_IDX_FORCE) |=> reg_rdata_q == $past(motor_current))
        else $error("current byte not returned");
    rd_hold_a: assert property (!(ce && reg_rd) |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    tgt_echo_a: assert property (s_rd(GRAC_IDX_TARGET) ##0 tgt_ok_q |=> reg_rdata_q == $past(tgt_q))
        else $error("target echo differs");
    status_spare_a: assert property (s_rd(GRAC_IDX_ACTION) |=> reg_rdata_q[2:1] == 2'h0)
        else $error("spare status bits set");
    echo_go_a: assert property (s_rd(GRAC_IDX_ACTION) ##0 !go_q |=> !reg_rdata_q[3])
        else $error("go echo without go");
    idle_still_a: assert property (quiet_q && ce |=> $stable(finger_position))
        else $error("fingers moved while not activated");
    idle_quiet_a: assert property (quiet_q |=> !motion_active)
        else $error("motion while not activated");
endmodule : grac_control_chk

bind grac_control grac_control_chk #(.ADDR_W(ADDR_W)) chk_i (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q),
    .motor_current(motor_current),
    .finger_position(finger_position),
    .motion_active(motion_active)
);

// >>> testbench/grac_host_model.sv
// grac_host_model: robot controller side, byte writes and reads.
// assumes one-cycle strobes sampled on the rising edge of clk.
`timescale 1ns/1ps
module grac_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata_q,
    output logic ce,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [7:0] motor_current
);
    // idle bus at time zero
    initial begin
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        motor_current = 8'h00;
    end

    // one byte write, lines scrambled once released
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_wr = 1'b1;
        reg_addr = a; // zero-based byte index
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // drive current sample seen by the design
    task automatic set_current(input logic [7:0] c);
        motor_current = c;
    endtask : set_current

    // one byte read, data taken the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_q;
    endtask : rd
endmodule : grac_host_model

// >>> testbench/grac_control_tb.sv
// grac_control_tb: register-level tests of activation, go-to and release.
// assumes grac_host_model as the only bus master.
`timescale 1ns/1ps
module grac_control_tb
    import grac_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce, reg_wr, reg_rd, motion_active;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_q, motor_current, finger_position, rv, p;
    int errors = 0;
    int comparisons = 0;

    // 10 MHz clock
    always #50 clk = ~clk;

    grac_control dut (.clk(clk), .reset(reset), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .motor_current(motor_current),
        .finger_position(finger_position), .motion_active(motion_active));
    grac_host_model host (.clk(clk), .reg_rdata_q(reg_rdata_q), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .motor_current(motor_current));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    // wait for the fingers to reach a position, bounded
    task automatic wait_pos(input logic [7:0] exp, input int lim);
        int n;
        n = 0;
        while (finger_position !== exp && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(finger_position, exp);
    endtask : wait_pos

    // poll status until activation completes
    task automatic wait_ready();
        rv = 8'h00;
        for (int i = 0; i < 20 && rv[5:4] !== GRAC_STA_DONE; i++) host.rd(GRAC_IDX_ACTION, rv);
    endtask : wait_ready

    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge clk);
        #1;
        reset = 1'b0;
        // go after power-up without clear then set
        host.wr(GRAC_IDX_TARGET, 8'h40);
        host.wr(GRAC_IDX_ACTION, 8'h09);
        repeat (20) @(posedge clk);
        check(finger_position, 8'h00);
        host.rd(GRAC_IDX_FAULT, rv);
        check(rv, GRAC_FLT_NONE);
        // action with activate clear
        host.wr(GRAC_IDX_ACTION, 8'h00);
        host.wr(GRAC_IDX_ACTION, 8'h08);
        host.rd(GRAC_IDX_FAULT, rv);
        check(rv, GRAC_FLT_NO_ACT);
        check(finger_position, 8'h00);
        host.wr(GRAC_IDX_ACTION, 8'h00);
        host.rd(GRAC_IDX_FAULT, rv);
        check(rv, GRAC_FLT_NONE);
        // activation
        host.wr(GRAC_IDX_ACTION, 8'h01);
        wait_ready();
        check(8'(rv[5:4]), 8'(GRAC_STA_DONE));
        check(8'(rv[3]), 8'h00);
        // go-to with full speed and force
        host.wr(GRAC_IDX_TARGET, 8'h10);
        host.wr(GRAC_IDX_SPEED, 8'hFF);
        host.wr(GRAC_IDX_FORCE, 8'hFF);
        host.wr(GRAC_IDX_ACTION, 8'h09);
        check(8'(motion_active), 8'h01);
        wait_pos(8'h10, 100);
        host.rd(GRAC_IDX_TARGET, rv);
        check(rv, 8'h10);
        host.rd(GRAC_IDX_ACTION, rv);
        check(8'(rv[7:3]), {3'h0, GRAC_OBJ_AT_TARGET, GRAC_STA_DONE, 1'b1});
        host.set_current(8'h22);
        host.rd(GRAC_IDX_FORCE, rv);
        check(rv, 8'h22);
        host.rd(GRAC_IDX_SPEED, rv);
        check(rv, 8'h10);
        // stop: new target without go
        host.wr(GRAC_IDX_ACTION, 8'h01);
        host.wr(GRAC_IDX_TARGET, 8'h80);
        repeat (20) @(posedge clk);
        check(finger_position, 8'h10);
        check(8'(motion_active), 8'h00);
        host.rd(GRAC_IDX_ACTION, rv);
        check(8'(rv[3]), 8'h00);
        // contact: current above force while closing
        host.wr(GRAC_IDX_FORCE, 8'h05);
        host.wr(GRAC_IDX_ACTION, 8'h09);
        repeat (10) @(posedge clk);
        host.rd(GRAC_IDX_ACTION, rv);
        check(8'(rv[7:6]), 8'(GRAC_OBJ_CLOSING));
        // reserved bits and bytes
        host.wr(GRAC_IDX_ACTION, 8'hC7);
        host.rd(GRAC_IDX_ACTION, rv);
        check(8'(rv[2:1]), 8'h00);
        host.wr(GRAC_IDX_SPARE1, 8'hAA);
        host.rd(GRAC_IDX_SPARE1, rv);
        check(rv, 8'h00);
        host.rd(4'h6, rv);
        check(rv, 8'h00);
        // opening auto release with go also set, direction in the same write
        host.set_current(8'h00);
        p = finger_position;
        host.wr(GRAC_IDX_ACTION, 8'h39);
        repeat (600) @(posedge clk);
        check(8'(finger_position < p), 8'h01);
        host.wr(GRAC_IDX_ACTION, 8'h19);
        wait_pos(GRAC_POS_OPEN, 6000);
        repeat (4) @(posedge clk);
        host.rd(GRAC_IDX_FAULT, rv);
        check(rv, GRAC_FLT_REL_DONE);
        host.wr(GRAC_IDX_ACTION, 8'h09);
        repeat (20) @(posedge clk);
        check(finger_position, GRAC_POS_OPEN);
        // recovery by clear then set
        host.wr(GRAC_IDX_ACTION, 8'h00);
        host.wr(GRAC_IDX_ACTION, 8'h01);
        wait_ready();
        host.wr(GRAC_IDX_ACTION, 8'h09);
        wait_pos(8'h80, 2000);
        summarize();
    end
endmodule : grac_control_tb
